// ---- include/sms_pkg.sv ----
// sms_pkg: constants and carrier types of the stepping sequencer.
// assumes a single 100 MHz clock; all pins synchronous to it.
`default_nettype none

package sms_pkg;

	// -----------------------------------------------------------------
	// clock and timing
	// -----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int POS_W = 6;
	localparam int RATIO_W = 7;
	localparam logic [POS_W-1:0] POS_RESET = 6'h00;
	localparam logic [RATIO_W-1:0] RATIO_FULL = 7'h64;
	localparam logic [RATIO_W-1:0] RATIO_HALF_LOW = 7'h47;

	// -----------------------------------------------------------------
	// interrupt status layout
	// -----------------------------------------------------------------
	localparam int IRQ_W = 3;
	localparam int IRQ_STEP_BIT = 0;
	localparam int IRQ_OVERCUR_BIT = 1;
	localparam int IRQ_OVERHEAT_BIT = 2;

	// -----------------------------------------------------------------
	// register port map
	// -----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
	localparam logic [ADDR_W-1:0] REG_POSITION = 4'h8;
	localparam logic [ADDR_W-1:0] REG_DRIVE = 4'hc;
	localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;

	// fault output encoding (none, overcurrent, overheat)
	localparam logic [1:0] FAULT_NONE = 2'h0;
	localparam logic [1:0] FAULT_OVERCUR = 2'h1;
	localparam logic [1:0] FAULT_OVERHEAT = 2'h2;

	typedef enum logic [2:0] {
		SMS_FULL,
		SMS_HALF,
		SMS_QUARTER,
		SMS_EIGHTH,
		SMS_SIXTEENTH
	} sms_mode_type;

	typedef struct packed {
		logic phase_a;
		logic phase_ab;
		logic phase_b;
		logic phase_bb;
		logic [RATIO_W-1:0] ratio_a;
		logic [RATIO_W-1:0] ratio_b;
	} sms_drive_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} sms_bus_req_type;

	// percent of peak winding current for angle index 0..16 sixteenths
	function automatic logic [RATIO_W-1:0] sms_ratio(input logic [4:0] k);
		logic [RATIO_W-1:0] r;
		r = 7'h00;
		unique case (k)
			5'h00: r = 7'h00;
			5'h01: r = 7'h0b;
			5'h02: r = 7'h14;
			5'h03: r = 7'h1e;
			5'h04: r = 7'h28;
			5'h05: r = 7'h2f;
			5'h06: r = 7'h37;
			5'h07: r = 7'h40;
			5'h08: r = 7'h47;
			5'h09: r = 7'h4d;
			5'h0a: r = 7'h53;
			5'h0b: r = 7'h57;
			5'h0c: r = 7'h5d;
			5'h0d: r = 7'h5f;
			5'h0e: r = 7'h61;
			5'h0f: r = 7'h64;
			default: r = 7'h64;
		endcase
		return r;
	endfunction : sms_ratio

endpackage : sms_pkg

`default_nettype wire

// ---- logic/sms_sequencer.sv ----
// sms_sequencer: phase sequencer, current ratio table, fault latch,
// excitation monitor and a small register port with interrupt.
// assumes every pin is synchronous to clk_i and cleanly levelled.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`default_nettype none

module sms_sequencer
	import sms_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// host control pins
	input wire logic step_clock_i,
	input wire logic rotation_direction_i,
	input wire logic mode_bit_lo_i,
	input wire logic mode_bit_hi_i,
	input wire logic edge_bit_i,
	input wire logic output_enable_i,
	// fault detectors
	input wire logic overcurrent_i,
	input wire logic overheat_i,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic irq_o,
	// drive and status outputs
	output sms_drive_type drive_o,
	output logic excitation_monitor_out_o,
	output logic fault_flag_n_o,
	output logic fault_flag_n_oe_o,
	output logic [1:0] fault_level_out_o
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic clk_prev;
		logic [POS_W-1:0] pos;
		logic overcur;
		logic overheat;
		logic monitor;
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
		logic [31:0] rdata;
		sms_drive_type drive;
	} sms_state_type;

	sms_state_type s_q, s_d;
	sms_mode_type mode;
	logic rise, fall, step, enabled, fault;
	logic [POS_W-1:0] inc;
	logic [POS_W-1:0] pos_next;
	logic [IRQ_W-1:0] events;
	sms_bus_req_type req;

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	// snap a position to the grid of the mode so coarse modes pick table
	// entries only; phase itself is never lost on a mode change
	function automatic logic [POS_W-1:0] sms_snap(input logic [POS_W-1:0] p,
			input sms_mode_type m);
		logic [POS_W-1:0] r;
		r = p;
		unique case (m)
			SMS_FULL: r = {p[5:4], 4'h8};
			SMS_HALF: r = {p[5:3], 3'h0};
			SMS_QUARTER: r = {p[5:2], 2'h0};
			SMS_EIGHTH: r = {p[5:1], 1'h0};
			SMS_SIXTEENTH: r = p;
		endcase
		return r;
	endfunction : sms_snap

	// -----------------------------------------------------------------
	// mode decode
	// -----------------------------------------------------------------
	always_comb begin
		mode = SMS_FULL;
		unique case ({edge_bit_i, mode_bit_hi_i, mode_bit_lo_i})
			3'h4: mode = SMS_FULL;
			3'h5: mode = SMS_HALF;
			3'h6: mode = SMS_QUARTER;
			3'h7: mode = SMS_EIGHTH;
			3'h0: mode = SMS_HALF;
			3'h1: mode = SMS_QUARTER;
			3'h2: mode = SMS_EIGHTH;
			3'h3: mode = SMS_SIXTEENTH;
		endcase
	end

	always_comb begin
		inc = 6'h01;
		unique case (mode)
			SMS_FULL: inc = 6'h10;
			SMS_HALF: inc = 6'h08;
			SMS_QUARTER: inc = 6'h04;
			SMS_EIGHTH: inc = 6'h02;
			SMS_SIXTEENTH: inc = 6'h01;
		endcase
	end

	assign fault = s_q.overcur | s_q.overheat;
	assign enabled = output_enable_i;
	assign rise = step_clock_i & ~s_q.clk_prev;
	assign fall = ~step_clock_i & s_q.clk_prev;
	assign step = enabled & (rise | (fall & ~edge_bit_i));
	assign pos_next = rotation_direction_i ? s_q.pos - inc : s_q.pos + inc;
	assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i,
		rd: reg_rd_i};

	always_comb begin
		events = '0;
		events[IRQ_STEP_BIT] = step;
		events[IRQ_OVERCUR_BIT] = overcurrent_i & ~s_q.overcur;
		events[IRQ_OVERHEAT_BIT] = overheat_i & ~s_q.overheat;
	end

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		logic [POS_W-1:0] p;
		logic [3:0] off;
		logic [RATIO_W-1:0] ra, rb;
		p = '0;
		off = '0;
		ra = '0;
		rb = '0;
		s_d = s_q;
		// tracked even while disabled, so an edge made then is dropped
		// on resume instead of being replayed as a late step
		s_d.clk_prev = step_clock_i;
		if (step) begin
			s_d.pos = pos_next;
			s_d.monitor = ~s_q.monitor;
		end
		// latch faults until reset
		if (overcurrent_i) begin
			s_d.overcur = 1'b1;
		end
		if (overheat_i) begin
			s_d.overheat = 1'b1;
		end
		// sine/cosine from snapped position; quadrant gives polarity
		p = sms_snap(s_d.pos, mode);
		off = p[3:0];
		ra = sms_ratio({1'b0, off});
		rb = sms_ratio(5'h10 - {1'b0, off});
		if (mode == SMS_FULL) begin
			ra = RATIO_FULL;
			rb = RATIO_FULL;
		end
		if (mode == SMS_HALF) begin
			// rising-edge half step holds full current on each energised winding; a is off at offset 0
			if (edge_bit_i) begin
				ra = (off == 4'h0) ? 7'h00 : RATIO_FULL;
				rb = RATIO_FULL;
			end else if (off != 4'h0) begin
				ra = RATIO_HALF_LOW;
				rb = RATIO_HALF_LOW;
			end else begin
				ra = 7'h00;
				rb = RATIO_FULL;
			end
		end
		// odd quadrants run the table backwards: sine falls, cosine rises
		if (p[4]) begin
			{ra, rb} = {rb, ra};
		end
		s_d.drive.ratio_a = ra;
		s_d.drive.ratio_b = rb;
		s_d.drive.phase_a = ~p[5] & (ra != 7'h00);
		s_d.drive.phase_ab = p[5] & (ra != 7'h00);
		s_d.drive.phase_b = (p[5] ~^ p[4]) & (rb != 7'h00);
		s_d.drive.phase_bb = (p[5] ^ p[4]) & (rb != 7'h00);
		if (!output_enable_i || s_d.overcur || s_d.overheat) begin
			s_d.drive = '0;
		end
		// write-one-to-clear; a new event wins over the clear
		if (req.wr && req.addr == REG_STATUS) begin
			s_d.status = s_q.status & ~req.wdata[IRQ_W-1:0];
		end
		s_d.status = s_d.status | events;
		if (req.wr && req.addr == REG_MASK) begin
			s_d.mask = req.wdata[IRQ_W-1:0];
		end
		s_d.rdata = '0;
		if (req.rd) begin
			unique case (req.addr)
				REG_STATUS: s_d.rdata[IRQ_W-1:0] = s_q.status;
				REG_MASK: s_d.rdata[IRQ_W-1:0] = s_q.mask;
				REG_POSITION: s_d.rdata[POS_W-1:0] = s_q.pos;
				REG_DRIVE: s_d.rdata[$bits(sms_drive_type)-1:0] = s_q.drive;
				default: s_d.rdata = '0;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '{clk_prev: 1'b0, pos: POS_RESET, overcur: 1'b0,
				overheat: 1'b0, monitor: 1'b0, status: '0,
				mask: MASK_RESET, rdata: '0, drive: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign drive_o = s_q.drive;
	assign reg_rdata_o = s_q.rdata;
	assign irq_o = |(s_q.status & s_q.mask);
	assign excitation_monitor_out_o = s_q.monitor;
	assign fault_flag_n_o = 1'b0;
	assign fault_flag_n_oe_o = fault;
	// overheat takes priority when both are latched
	assign fault_level_out_o = s_q.overheat ? FAULT_OVERHEAT :
		(s_q.overcur ? FAULT_OVERCUR : FAULT_NONE);

endmodule : sms_sequencer

`default_nettype wire

// ---- verif/sms_assertions.sv ----
// sms_assertions: port-level properties of the stepping sequencer.
// assumes sms_pkg is compiled first; bound to every sms_sequencer.
`default_nettype none

module sms_assertions
	import sms_pkg::*;
(
	// watched ports
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic step_clock_i,
	input wire logic edge_bit_i,
	input wire logic output_enable_i,
	input wire logic overcurrent_i,
	input wire logic overheat_i,
	input wire sms_drive_type drive_o,
	input wire logic excitation_monitor_out_o,
	input wire logic fault_flag_n_o,
	input wire logic fault_flag_n_oe_o,
	input wire logic [1:0] fault_level_out_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	a_fault_latch: assert property (overcurrent_i || overheat_i |=>
		fault_flag_n_oe_o) else $error("fault not latched");
	a_fault_hold: assert property (fault_flag_n_oe_o |=>
		fault_flag_n_oe_o) else $error("fault released early");
	a_fault_off: assert property (fault_flag_n_oe_o |=>
		drive_o == '0) else $error("drive on while faulted");
	a_disable_off: assert property (!output_enable_i |=>
		drive_o == '0) else $error("drive on while disabled");
	a_flag_low: assert property (fault_flag_n_o == 1'b0)
		else $error("fault flag pin not pulled low");
	a_heat_level: assert property (overheat_i |=>
		fault_level_out_o == FAULT_OVERHEAT) else $error("bad level");
	a_freeze_mon: assert property (!output_enable_i |=>
		$stable(excitation_monitor_out_o)) else $error("moved when off");
	a_rise_only: assert property ($changed(excitation_monitor_out_o) &&
		$past(edge_bit_i) |-> $past(step_clock_i)) else $error("fall step");
	a_ratio_cap: assert property (drive_o.ratio_a <= RATIO_FULL &&
		drive_o.ratio_b <= RATIO_FULL) else $error("ratio above peak");

	c_fault: cover property (fault_flag_n_oe_o);
	c_both_edge: cover property ($changed(excitation_monitor_out_o) &&
		!$past(edge_bit_i));
	c_off_step: cover property (!output_enable_i && $changed(step_clock_i));

endmodule : sms_assertions

bind sms_sequencer sms_assertions u_sms_assertions (.clk_i(clk_i),
	.resetn_i(resetn_i), .step_clock_i(step_clock_i),
	.edge_bit_i(edge_bit_i), .output_enable_i(output_enable_i),
	.overcurrent_i(overcurrent_i), .overheat_i(overheat_i),
	.drive_o(drive_o), .excitation_monitor_out_o(excitation_monitor_out_o),
	.fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe_o(fault_flag_n_oe_o),
	.fault_level_out_o(fault_level_out_o));

`default_nettype wire

// ---- verif/sms_host_model.sv ----
// sms_host_model: host side issuing step commands.
// assumes the bench calls step() right after a clock edge.
`default_nettype none

module sms_host_model (
	// clock
	input wire logic clk_i,
	// step command pins
	output logic step_clock_o,
	output logic rotation_direction_o,
	output logic mode_bit_lo_o,
	output logic mode_bit_hi_o,
	output logic edge_bit_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------------------------
	// step command
	// ---------------------------------------------------------------
	initial begin
		step_clock_o = 1'b0;
		rotation_direction_o = 1'b0;
		{mode_bit_hi_o, mode_bit_lo_o, edge_bit_o} = 3'h1;
	end

	// mode and direction settle a cycle before the edge they qualify
	task automatic step(input logic dir, input logic [1:0] m,
		input logic e, input int hold);
		@(posedge clk_i);
		rotation_direction_o <= dir;
		{mode_bit_hi_o, mode_bit_lo_o} <= m;
		edge_bit_o <= e;
		@(posedge clk_i);
		step_clock_o <= ~step_clock_o;
		repeat (hold) @(posedge clk_i);
	endtask : step

endmodule : sms_host_model

`default_nettype wire

// ---- verif/tb.sv ----
// tb: self-checking bench for sms_sequencer against an integer model.
// assumes sms_pkg, the host model and the checker are compiled first.
`default_nettype none

module tb
	import sms_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------------------------
	// signals and model state
	// ---------------------------------------------------------------
	logic clk_i, resetn_i = 1'b0, output_enable_i = 1'b1;
	logic overcurrent_i = 1'b0, overheat_i = 1'b0;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, irq_o, mon, flag, oe;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
	logic [1:0] level;
	wire logic stp, dir, lo, hi, eb;
	sms_drive_type drive;
	int pos = 0, errors = 0, n_tests = 0;
	int tbl[17] = '{0, 11, 20, 30, 40, 47, 55, 64, 71, 77, 83, 87, 93,
		95, 97, 100, 100};
	integer seed = 32'heeebc694;
	logic mon_m = 1'b0;

	sms_host_model u_sms_host_model (.clk_i(clk_i), .step_clock_o(stp),
		.rotation_direction_o(dir), .mode_bit_lo_o(lo),
		.mode_bit_hi_o(hi), .edge_bit_o(eb));
	sms_sequencer u_sms_sequencer (.clk_i(clk_i), .resetn_i(resetn_i),
		.step_clock_i(stp), .rotation_direction_i(dir),
		.mode_bit_lo_i(lo), .mode_bit_hi_i(hi), .edge_bit_i(eb),
		.output_enable_i(output_enable_i), .overcurrent_i(overcurrent_i),
		.overheat_i(overheat_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
		.drive_o(drive), .excitation_monitor_out_o(mon),
		.fault_flag_n_o(flag), .fault_flag_n_oe_o(oe),
		.fault_level_out_o(level));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		// data stand in the cycle after the strobe; taken at its closing edge
		@(posedge clk_i);
		d = reg_rdata_o;
	endtask : rd

	// one host step, then position and monitor compared, ratio pair and polarity only while output is enabled
	task automatic step(input logic [1:0] m, input logic e);
		int inc, k, a, b;
		logic r;
		logic [3:0] pe;
		r = 1'($random(seed));
		u_sms_host_model.step(r, m, e, 2 + ($random(seed) & 3));
		inc = e ? (16 >> m) : (8 >> m);
		if (output_enable_i && (stp || !e)) begin
			pos = (pos + (r ? 64 - inc : inc)) % 64;
			mon_m = ~mon_m;
		end
		rd(REG_POSITION);
		chk("position", d, pos);
		chk("monitor", mon, mon_m);
		k = pos % 16;
		k = k - k % inc;
		a = tbl[k];
		b = tbl[16-k];
		// rising-edge full and half steps run energised windings at full current (half: a off at k 0)
		if (e && m < 2) begin
			a = (m == 1 && k == 0) ? 0 : 100;
			b = 100;
		end
		// sine falls and cosine rises through the odd quadrants
		if (pos % 32 >= 16) begin
			{a, b} = {b, a};
		end
		pe = {a != 0 && pos < 32, a != 0 && pos >= 32,
			b != 0 && (pos < 16 || pos >= 48), b != 0 && pos >= 16 && pos < 48};
		if (output_enable_i) begin
			chk("ratio a", drive.ratio_a, a);
			chk("ratio b", drive.ratio_b, b);
			chk("polarity", drive[17:14], pe);
		end
	endtask : step

	task automatic summarize();
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	// ---------------------------------------------------------------
	// sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		summarize();
	end

	initial begin
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(REG_MASK);
		chk("mask reset", d, 32'h0);
		rd(4'h2);
		chk("unmapped", d, 32'h0);
		for (int e = 1; e >= 0; e--)
			for (int m = 0; m < 4; m++)
				repeat (4) step(2'(m), 1'(e));
		rd(REG_STATUS);
		chk("step event", d[IRQ_STEP_BIT], 1'b1);
		wr(REG_MASK, 32'h1);
		@(posedge clk_i);
		chk("irq on", irq_o, 1'b1);
		wr(REG_STATUS, 32'h1);
		@(posedge clk_i);
		chk("irq off", irq_o, 1'b0);
		output_enable_i <= 1'b0;
		// odd count leaves a level change that must not step on resume
		repeat (3) step(2'h3, 1'b0);
		chk("drive off", drive, 32'h0);
		output_enable_i <= 1'b1;
		step(2'h3, 1'b0);
		if (stp) step(2'h3, 1'b0);
		@(posedge clk_i) overcurrent_i <= 1'b1;
		@(posedge clk_i) overcurrent_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("level oc", level, FAULT_OVERCUR);
		chk("drive oc", drive, 32'h0);
		chk("flag on", oe, 1'b1);
		chk("flag pin", flag, 1'b0);
		rd(REG_STATUS);
		chk("oc event", d[IRQ_OVERCUR_BIT], 1'b1);
		@(posedge clk_i) overheat_i <= 1'b1;
		@(posedge clk_i) overheat_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("level oh", level, FAULT_OVERHEAT);
		chk("flag held", oe, 1'b1);
		resetn_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(REG_POSITION);
		chk("position reset", d, 32'h0);
		chk("fault cleared", {oe, level}, 3'h0);
		summarize();
	end

endmodule : tb

`default_nettype wire
